// file: logic/chimd_cfg.svh
// Offsets, field positions and reset values of the card host register bank
`ifndef CHIMD_CFG_SVH
`define CHIMD_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CHIMD_ADDR_IRQ_ENABLE 32'h40000044
`define CHIMD_ADDR_IRQ_DISABLE 32'h40000048
`define CHIMD_ADDR_IRQ_VIEW 32'h4000004c
`define CHIMD_ADDR_DMA_SETUP 32'h40000050
`define CHIMD_ADDR_WRITE_PROT 32'h40000058
`define CHIMD_ADDR_EVT_STATUS 32'h40000060
`define CHIMD_ADDR_EVT_CLEAR 32'h40000064

// ****************************************************************
// Field layout
// ****************************************************************
`define CHIMD_IRQ_VALID 32'hffff333f
`define CHIMD_IRQ_UNDERRUN_BIT 31
`define CHIMD_IRQ_CMD_DONE_BIT 0
`define CHIMD_DMA_VALID 32'h00001113
`define CHIMD_DMA_SKIP_LSB 0
`define CHIMD_DMA_SKIP_MSB 1
`define CHIMD_DMA_CHUNK_BIT 4
`define CHIMD_DMA_HS_BIT 8
`define CHIMD_DMA_PAD_BIT 12
`define CHIMD_WP_BIT 0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CHIMD_MASK_RST 32'h00000000
`define CHIMD_STATUS_RST 32'h00000000
`define CHIMD_DMA_RST 32'h00000000
`define CHIMD_WP_RST 1'h0
`define CHIMD_CHUNK_ONE 3'h1
`define CHIMD_CHUNK_FOUR 3'h4

`endif

// file: logic/chimd_pkg.sv
// Types shared by the card host register bank
`default_nettype none

package chimd_pkg;

  // ****************************************************************
  // Bus request and register contents
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } chimd_wbreq_s;

  typedef struct packed {
    logic readPadding;
    logic handshakeOn;
    logic chunkFour;
    logic [1:0] byteSkip;
  } chimd_dmacfg_s;

  typedef struct packed {
    logic [16:0] bytes;
    logic twoDescriptors;
  } chimd_xfer_s;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] status;
    logic irq;
  } chimd_irq_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic wpOn;
    chimd_dmacfg_s cfg;
    chimd_xfer_s xfer;
    logic chunkReq;
  } chimd_top_s;

  // Byte lanes of a write, widened to a bit mask
  function automatic logic [31:0] chimd_lane_mask(input logic [3:0] sel);
    chimd_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

endpackage

`default_nettype wire

// file: logic/chimd_irq_bank.sv
// Interrupt enable view, sticky event status and interrupt line
`include "chimd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module chimd_irq_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write strobes, data already gated by byte lanes
  input wire logic setEn,
  input wire logic clrEn,
  input wire logic statusClr,
  input wire logic [31:0] wrBits,
  // Event sources
  input wire logic [31:0] events,
  // Register views and interrupt
  output logic [31:0] maskView,
  output logic [31:0] statusView,
  output logic irq
);

  chimd_pkg::chimd_irq_s s_r;
  chimd_pkg::chimd_irq_s s_nxt;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (setEn) begin
      s_nxt.mask = s_r.mask | wrBits; // [R11]
    end
    if (clrEn) begin
      s_nxt.mask = s_r.mask & ~wrBits; // [R01]
    end
    s_nxt.mask = s_nxt.mask & `CHIMD_IRQ_VALID; // [R03] [R13]
    // Set wins over clear so a same-cycle event is kept
    s_nxt.status = statusClr ? (s_r.status & ~wrBits) : s_r.status;
    s_nxt.status = (s_nxt.status | events) & `CHIMD_IRQ_VALID;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask); // [R12]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.mask <= `CHIMD_MASK_RST; // [R12]
      s_r.status <= `CHIMD_STATUS_RST;
      s_r.irq <= 1'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign maskView = s_r.mask; // [R02]
  assign statusView = s_r.status;
  assign irq = s_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_disable_write;
    clrEn ##1 1'b1;
  endsequence

  property p_disable_clears;
    s_disable_write |-> (maskView & $past(wrBits)) == 32'h00000000;
  endproperty
  a_disable_clears: assert property (p_disable_clears) // [R01]
    else $error("disable write left an enable set");

  property p_disable_keeps;
    clrEn |=> ((maskView ^ $past(maskView)) & ~$past(wrBits)) == 32'h00000000;
  endproperty
  a_disable_keeps: assert property (p_disable_keeps) // [R01]
    else $error("disable write touched a zero bit");

  property p_enable_sets;
    setEn |=> (maskView & $past(wrBits) & `CHIMD_IRQ_VALID)
      == ($past(wrBits) & `CHIMD_IRQ_VALID);
  endproperty
  a_enable_sets: assert property (p_enable_sets) // [R11]
    else $error("enable write did not set mask");

  property p_reserved_zero;
    (maskView & ~`CHIMD_IRQ_VALID) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R03]
    else $error("reserved mask bit set");

  property p_irq_level;
    irq == |(statusView & maskView);
  endproperty
  a_irq_level: assert property (p_irq_level) // [R12]
    else $error("interrupt line disagrees with status and mask");

  property p_event_sticky;
    (|(events & `CHIMD_IRQ_VALID)) |=>
      (statusView & $past(events & `CHIMD_IRQ_VALID)) == $past(events & `CHIMD_IRQ_VALID);
  endproperty
  a_event_sticky: assert property (p_event_sticky) // [R12]
    else $error("event lost from status");

endmodule // chimd_irq_bank

`default_nettype wire

// file: logic/chimd_xfer_len.sv
// Byte count and descriptor need of one card-to-memory block
`timescale 1ns/1ps
`default_nettype none

module chimd_xfer_len (
  // Block geometry
  input wire logic [15:0] blockLength,
  input wire logic readPadding,
  // Result
  output chimd_pkg::chimd_xfer_s xfer
);

  logic [16:0] rounded;

  always_comb begin
    rounded = {1'b0, blockLength} + 17'h00003;
    xfer.bytes = {1'b0, blockLength}; // [R09]
    xfer.twoDescriptors = 1'h0;
    if (readPadding) begin
      // Padding spares software a second descriptor
      xfer.bytes = {rounded[16:2], 2'h0}; // [R10]
    end else begin
      xfer.twoDescriptors = |blockLength[1:0]; // [R09]
    end
  end

endmodule // chimd_xfer_len

`default_nettype wire

// file: logic/chimd_top.sv
// Card host interrupt mask and DMA setup register bank on classic Wishbone
//
// Function
// R01: Disable write one clears matching enable
// R02: Mask read shows enabled sources, ignores writes
// R03: Shared layout, reserved bits 6,7,10,11,14,15
// R04: DMA setup writable only without write protect
// R05: Bits 1:0 give first-word byte skip
// R06: Bit 4 chunk: one or four items
// R07: Bit 8 turns handshake interface on
// R08: Software disables handshake during processor transfers
// R09: No padding moves exact block length
// R10: Padding bit 12 rounds length up
// R11: Enable write one sets matching enable
// R12: Interrupt while flagged and enabled; reset clears
// R13: Reserved bits read zero, writes ignored
`include "chimd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module chimd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Interrupt sources and line
  input wire logic [31:0] irqEvents,
  output logic irq,
  // Card and DMA side
  input wire logic [15:0] blockLength,
  input wire logic [2:0] dataAvail,
  output logic [1:0] dmaByteSkip,
  output logic dmaChunkFour,
  output logic dmaHandshakeOn,
  output logic dmaReadPadding,
  output logic [16:0] dmaXferBytes,
  output logic dmaTwoDescriptors,
  output logic dmaChunkReq
);

  chimd_pkg::chimd_wbreq_s req;
  chimd_pkg::chimd_top_s s_r;
  chimd_pkg::chimd_top_s s_nxt;
  chimd_pkg::chimd_xfer_s xferCalc;
  logic take;
  logic takeWr;
  logic [31:0] lanes;
  logic [31:0] wrBits;
  logic wrEnable;
  logic wrDisable;
  logic wrStatusClr;
  logic wrDma;
  logic [31:0] maskView;
  logic [31:0] statusView;
  logic [31:0] dmaWord;
  logic [31:0] dmaNew;
  logic [2:0] chunkNeed;
  chimd_pkg::chimd_dmacfg_s cfgNxt;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  // Ack drops after one cycle, so a held request is taken once
  assign take = req.cyc && req.stb && !s_r.ack;
  assign takeWr = take && req.we;
  assign lanes = chimd_pkg::chimd_lane_mask(req.sel);
  // Lanes left out count as zero, which leaves set/clear bits alone
  assign wrBits = req.dat & lanes;
  assign wrEnable = takeWr && (req.adr == `CHIMD_ADDR_IRQ_ENABLE);
  assign wrDisable = takeWr && (req.adr == `CHIMD_ADDR_IRQ_DISABLE);
  assign wrStatusClr = takeWr && (req.adr == `CHIMD_ADDR_EVT_CLEAR);
  assign wrDma = takeWr && (req.adr == `CHIMD_ADDR_DMA_SETUP) && !s_r.wpOn; // [R04]

  // ****************************************************************
  // Interrupt bank and length calculation
  // ****************************************************************
  chimd_irq_bank u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .setEn(wrEnable),
    .clrEn(wrDisable),
    .statusClr(wrStatusClr),
    .wrBits(wrBits),
    .events(irqEvents),
    .maskView(maskView),
    .statusView(statusView),
    .irq(irq)
  );

  chimd_xfer_len u_len (
    .blockLength(blockLength),
    .readPadding(cfgNxt.readPadding),
    .xfer(xferCalc)
  );

  // ****************************************************************
  // Register image
  // ****************************************************************
  always_comb begin
    dmaWord = 32'h00000000;
    dmaWord[`CHIMD_DMA_SKIP_MSB:`CHIMD_DMA_SKIP_LSB] = s_r.cfg.byteSkip;
    dmaWord[`CHIMD_DMA_CHUNK_BIT] = s_r.cfg.chunkFour;
    dmaWord[`CHIMD_DMA_HS_BIT] = s_r.cfg.handshakeOn;
    dmaWord[`CHIMD_DMA_PAD_BIT] = s_r.cfg.readPadding;
    dmaNew = ((dmaWord & ~lanes) | wrBits) & `CHIMD_DMA_VALID; // [R13]
    // Kept apart from the state copy so length and request logic form no loop
    cfgNxt = s_r.cfg;
    if (wrDma) begin
      cfgNxt.byteSkip = dmaNew[`CHIMD_DMA_SKIP_MSB:`CHIMD_DMA_SKIP_LSB]; // [R05]
      cfgNxt.chunkFour = dmaNew[`CHIMD_DMA_CHUNK_BIT]; // [R06]
      cfgNxt.handshakeOn = dmaNew[`CHIMD_DMA_HS_BIT]; // [R07]
      cfgNxt.readPadding = dmaNew[`CHIMD_DMA_PAD_BIT]; // [R10]
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = take;
    s_nxt.dat = 32'h00000000;
    if (take && !req.we) begin
      case (req.adr)
        `CHIMD_ADDR_IRQ_VIEW: s_nxt.dat = maskView; // [R02]
        `CHIMD_ADDR_DMA_SETUP: s_nxt.dat = dmaWord; // [R13]
        `CHIMD_ADDR_WRITE_PROT: s_nxt.dat = {31'h00000000, s_r.wpOn};
        `CHIMD_ADDR_EVT_STATUS: s_nxt.dat = statusView;
        default: s_nxt.dat = 32'h00000000;
      endcase
    end
    if (takeWr && (req.adr == `CHIMD_ADDR_WRITE_PROT) && req.sel[0]) begin
      s_nxt.wpOn = req.dat[`CHIMD_WP_BIT];
    end
    s_nxt.cfg = cfgNxt; // [R04]
    s_nxt.xfer = xferCalc; // [R09] [R10]
    // Request held low with handshake off so processor moves are safe
    s_nxt.chunkReq = cfgNxt.handshakeOn && (dataAvail >= chunkNeed); // [R06] [R07] [R08]
  end

  assign chunkNeed = cfgNxt.chunkFour ? `CHIMD_CHUNK_FOUR : `CHIMD_CHUNK_ONE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.ack <= 1'h0;
      s_r.dat <= 32'h00000000;
      s_r.wpOn <= `CHIMD_WP_RST;
      s_r.cfg <= '0;
      s_r.xfer <= '0;
      s_r.chunkReq <= 1'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign dmaByteSkip = s_r.cfg.byteSkip;
  assign dmaChunkFour = s_r.cfg.chunkFour;
  assign dmaHandshakeOn = s_r.cfg.handshakeOn;
  assign dmaReadPadding = s_r.cfg.readPadding;
  assign dmaXferBytes = s_r.xfer.bytes;
  assign dmaTwoDescriptors = s_r.xfer.twoDescriptors;
  assign dmaChunkReq = s_r.chunkReq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_protected_dma_write;
    takeWr && (req.adr == `CHIMD_ADDR_DMA_SETUP) && s_r.wpOn;
  endsequence

  property p_protect_blocks;
    s_protected_dma_write |=> $stable(s_r.cfg);
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) // [R04]
    else $error("protected setup register changed");

  property p_view_read_only;
    (takeWr && (req.adr == `CHIMD_ADDR_IRQ_VIEW)) |=> maskView == $past(maskView);
  endproperty
  a_view_read_only: assert property (p_view_read_only) // [R02]
    else $error("write to mask view changed it");

  property p_skip_write;
    (wrDma && req.sel[0]) |=> dmaByteSkip == $past(req.dat[1:0]);
  endproperty
  a_skip_write: assert property (p_skip_write) // [R05]
    else $error("byte skip not taken");

  property p_chunk_gate;
    dmaChunkReq |-> dmaHandshakeOn;
  endproperty
  a_chunk_gate: assert property (p_chunk_gate) // [R07]
    else $error("chunk request with handshake off");

  property p_chunk_four;
    (dmaHandshakeOn && dmaChunkFour && !wrDma) |=> (dmaChunkReq == ($past(dataAvail) >= 3'h4));
  endproperty
  a_chunk_four: assert property (p_chunk_four) // [R06]
    else $error("chunk request ignores four-item size");

  property p_exact_len;
    (!dmaReadPadding && !wrDma) |=>
      (dmaXferBytes == {1'b0, $past(blockLength)}) &&
      (dmaTwoDescriptors == ($past(blockLength[1:0]) != 2'h0));
  endproperty
  a_exact_len: assert property (p_exact_len) // [R09]
    else $error("exact length or descriptor count wrong");

  property p_padded_len;
    dmaReadPadding |-> (dmaXferBytes[1:0] == 2'h0) && !dmaTwoDescriptors;
  endproperty
  a_padded_len: assert property (p_padded_len) // [R10]
    else $error("padded length not a word multiple");

  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) // [R13]
    else $error("ack held longer than one cycle");

  sequence s_view_read;
    take && !req.we && (req.adr == `CHIMD_ADDR_IRQ_VIEW);
  endsequence

  sequence s_setup_read;
    take && !req.we && (req.adr == `CHIMD_ADDR_DMA_SETUP);
  endsequence

  sequence s_upper_lane_write;
    wrDma && req.sel[1];
  endsequence

  property p_view_read;
    s_view_read |=> wb_dat_o == $past(maskView);
  endproperty
  a_view_read: assert property (p_view_read) // [R02]
    else $error("mask view read returned wrong word");

  property p_setup_read;
    s_setup_read |=> wb_dat_o == {19'h0, $past(dmaReadPadding), 3'h0, $past(dmaHandshakeOn),
      3'h0, $past(dmaChunkFour), 2'h0, $past(dmaByteSkip)};
  endproperty
  a_setup_read: assert property (p_setup_read) // [R13]
    else $error("setup read returned wrong word");

  property p_disable_reads_zero;
    (take && !req.we && (req.adr == `CHIMD_ADDR_IRQ_DISABLE)) |=> wb_dat_o == 32'h00000000;
  endproperty
  a_disable_reads_zero: assert property (p_disable_reads_zero) // [R13]
    else $error("write-only register read not zero");

  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) // [R13]
    else $error("read data shown outside ack");

  property p_chunk_one;
    (dmaHandshakeOn && !dmaChunkFour && !wrDma) |=>
      (dmaChunkReq == ($past(dataAvail) >= 3'h1));
  endproperty
  a_chunk_one: assert property (p_chunk_one) // [R06]
    else $error("chunk request ignores one-item size");

  property p_chunk_write;
    (wrDma && req.sel[0]) |=> dmaChunkFour == $past(req.dat[`CHIMD_DMA_CHUNK_BIT]);
  endproperty
  a_chunk_write: assert property (p_chunk_write) // [R06]
    else $error("chunk size not taken");

  property p_handshake_write;
    s_upper_lane_write |=> dmaHandshakeOn == $past(req.dat[`CHIMD_DMA_HS_BIT]);
  endproperty
  a_handshake_write: assert property (p_handshake_write) // [R07]
    else $error("handshake enable not taken");

  property p_padding_write;
    s_upper_lane_write |=> dmaReadPadding == $past(req.dat[`CHIMD_DMA_PAD_BIT]);
  endproperty
  a_padding_write: assert property (p_padding_write) // [R10]
    else $error("read padding not taken");

  property p_padded_round;
    (dmaReadPadding && !wrDma) |=>
      dmaXferBytes == (({1'b0, $past(blockLength)} + 17'h00003) & 17'h1fffc);
  endproperty
  a_padded_round: assert property (p_padded_round) // [R10]
    else $error("padded length not rounded up");

endmodule // chimd_top

`default_nettype wire

// file: bench/chimd_far_model.sv
// Far-side model: card block geometry, DMA data level and event sources
`timescale 1ns/1ps
`default_nettype none

module chimd_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Scenario requests
  input wire logic [15:0] reqLen,
  input wire logic [2:0] reqAvail,
  input wire logic [31:0] reqEvents,
  // Far-side levels
  output logic [15:0] blockLength,
  output logic [2:0] dataAvail,
  output logic [31:0] irqEvents
);
  // ****************************************************************
  // Levels move only on the clock, never between edges
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blockLength <= 16'h0000;
      dataAvail <= 3'h0;
      irqEvents <= 32'h00000000;
    end else begin
      blockLength <= reqLen;
      dataAvail <= reqAvail;
      irqEvents <= reqEvents;
    end
  end
endmodule // chimd_far_model

`default_nettype wire

// file: bench/test_card_host_irq_mask_and_dma_config.sv
// Self-checking bench of the card host register bank
`timescale 1ns/1ps
`default_nettype none

module test_card_host_irq_mask_and_dma_config;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [31:0] EN = 32'h40000044;
  localparam logic [31:0] DIS = 32'h40000048;
  localparam logic [31:0] VIEW = 32'h4000004c;
  localparam logic [31:0] DMA = 32'h40000050;
  localparam logic [31:0] WP = 32'h40000058;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [31:0] wbAdr = 32'h0, wbDat = 32'h0, wbDatO, irqEvents, reqEvents = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic wbAck, irq, dmaChunkFour, dmaHandshakeOn, dmaReadPadding, dmaTwoDescriptors;
  logic dmaChunkReq;
  logic [1:0] dmaByteSkip;
  logic [15:0] blockLength, reqLen = 16'h0;
  logic [2:0] dataAvail, reqAvail = 3'h0;
  logic [16:0] dmaXferBytes;
  logic [31:0] expQ[$];
  int errors = 0, nTests = 0, cycles = 0;

  always #2.5 clk = ~clk;

  chimd_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_ack_o(wbAck), .wb_dat_o(wbDatO), .irqEvents(irqEvents), .irq(irq),
    .blockLength(blockLength), .dataAvail(dataAvail), .dmaByteSkip(dmaByteSkip),
    .dmaChunkFour(dmaChunkFour), .dmaHandshakeOn(dmaHandshakeOn),
    .dmaReadPadding(dmaReadPadding), .dmaXferBytes(dmaXferBytes),
    .dmaTwoDescriptors(dmaTwoDescriptors), .dmaChunkReq(dmaChunkReq));

  chimd_far_model far_u (.clk(clk), .rst_n(rst_n), .reqLen(reqLen), .reqAvail(reqAvail),
    .reqEvents(reqEvents), .blockLength(blockLength), .dataAvail(dataAvail),
    .irqEvents(irqEvents));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic completeRun();
    if (expQ.size() != 0) begin
      errors++;
      $display("ERROR t=%0t reads left unanswered", $time);
    end
    $display("Comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; request held until the edge that samples ack high
  task automatic wb(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("ERROR t=%0t no ack", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    wb(1'b0, adr, 4'hf, 32'h0);
  endtask

  task automatic far(input logic [15:0] len, input logic [2:0] av, input logic [31:0] ev);
    @(posedge clk);
    reqLen <= len;
    reqAvail <= av;
    reqEvents <= ev;
    @(posedge clk);
    reqEvents <= 32'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // ****************************************************************
  // Read-data monitor and timeout
  // ****************************************************************
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("ERROR t=%0t unexpected read ack", $time);
      end else begin
        chk(wbDatO, expQ.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      $display("ERROR t=%0t timeout", $time);
      completeRun();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] r, v;
    logic [31:0] cfg[5];
    logic [15:0] len[5];
    logic [2:0] av[5];
    logic [16:0] eb;
    cfg = '{32'h00001110, 32'h00000110, 32'h00000100, 32'h00001100, 32'h00000000};
    len = '{16'h000d, 16'h000d, 16'h0010, 16'hffff, 16'hffff};
    av = '{3'h3, 3'h4, 3'h1, 3'h0, 3'h7};
    void'($urandom(32'h2471bd05));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(VIEW, 32'h0);
    rd(DMA, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("Test reset done");
    // Set, clear, read-only and write-only places
    wb(1'b1, EN, 4'hf, 32'hffffffff);
    rd(VIEW, 32'hffff333f);
    r = $urandom();
    wb(1'b1, DIS, 4'hf, r);
    rd(VIEW, 32'hffff333f & ~r);
    wb(1'b1, VIEW, 4'hf, ~r);
    rd(VIEW, 32'hffff333f & ~r);
    rd(DIS, 32'h0);
    rd(32'h4000005c, 32'h0);
    wb(1'b1, EN, 4'hf, 32'hffffffff);
    wb(1'b1, DIS, 4'hf, 32'h7ffffffe);
    rd(VIEW, 32'h80000001);
    $display("Test mask done");
    // Only enabled events reach the line; status stays sticky
    wb(1'b1, DIS, 4'hf, 32'h00000001);
    far(16'h0, 3'h0, 32'h00000001);
    chk({31'h0, irq}, 32'h0);
    far(16'h0, 3'h0, 32'h80000000);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, DIS, 4'hf, 32'h80000000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, EN, 4'hf, 32'h00000001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(32'h40000060, 32'h80000001);
    wb(1'b1, 32'h40000064, 4'hf, 32'hffffffff);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("Test interrupt done");
    // Every field value, random reserved bits
    for (int i = 0; i < 8; i++) begin
      v = ($urandom() & ~32'h1113) | {19'h0, i[2], 3'h0, i[1], 3'h0, i[0], 2'h0, i[1:0]};
      wb(1'b1, DMA, 4'hf, v);
      rd(DMA, v & 32'h1113);
      chk({27'h0, dmaReadPadding, dmaHandshakeOn, dmaChunkFour, dmaByteSkip},
          {27'h0, v[12], v[8], v[4], v[1:0]});
    end
    wb(1'b1, DMA, 4'h2, 32'hffffffff);
    rd(DMA, (v & 32'h0013) | 32'h1100);
    wb(1'b1, WP, 4'hf, 32'h1);
    wb(1'b1, DMA, 4'hf, ~v);
    rd(DMA, (v & 32'h0013) | 32'h1100);
    wb(1'b1, WP, 4'hf, 32'h0);
    wb(1'b1, DMA, 4'hf, 32'h1113);
    rd(DMA, 32'h1113);
    $display("Test dma setup done");
    // Chunk request and transfer size from the far side levels
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, DMA, 4'hf, cfg[i]);
      far(len[i], av[i], 32'h0);
      eb = cfg[i][12] ? ({1'b0, len[i]} + 17'd3) & 17'h1fffc : {1'b0, len[i]};
      chk({15'h0, dmaXferBytes}, {15'h0, eb});
      chk({31'h0, dmaTwoDescriptors}, {31'h0, !cfg[i][12] && len[i][1:0] != 2'h0});
      chk({31'h0, dmaChunkReq},
          {31'h0, cfg[i][8] && av[i] >= (cfg[i][4] ? 3'd4 : 3'd1)});
    end
    // Handshake left off before any processor data movement
    wb(1'b1, DMA, 4'hf, 32'h0);
    chk({30'h0, dmaHandshakeOn, dmaChunkReq}, 32'h0);
    $display("Test dma levels done");
    completeRun();
  end
endmodule // test_card_host_irq_mask_and_dma_config

`default_nettype wire
